/* hdl/caf_pkg.sv */
// Package for the CAN receive acceptance filter: register map, fields, types.
package caf_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_FILT = 16;
  localparam int NUM_MASK = 3;
  localparam int NUM_BUF  = 15;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_PTR_BASE  = 8'h00;
  localparam logic [7:0] OFF_MSEL      = 8'h10;
  localparam logic [7:0] OFF_FEN       = 8'h14;
  localparam logic [7:0] OFF_FULL      = 8'h18;
  localparam logic [7:0] OFF_OVF       = 8'h1C;
  localparam logic [7:0] OFF_IST       = 8'h20;
  localparam logic [7:0] OFF_IMASK     = 8'h24;
  localparam logic [7:0] OFF_LAST      = 8'h28;
  localparam logic [7:0] OFF_FSID_BASE = 8'h40;
  localparam logic [7:0] OFF_FEID_BASE = 8'h80;
  localparam logic [7:0] OFF_MSID_BASE = 8'hC0;
  localparam logic [7:0] OFF_MEID_BASE = 8'hD0;

  // ****************************************************************
  // Field codes and reset values
  // ****************************************************************
  localparam logic [3:0]  PTR_FIFO  = 4'hF;
  localparam logic [1:0]  MSEL_NONE = 2'h3;
  localparam logic [15:0] PTR_RST   = 16'h0000;
  localparam logic [15:0] MSEL_RST  = 16'h0000;
  localparam logic [15:0] FEN_RST   = 16'h003F;
  localparam int          IST_BUF   = 0;
  localparam int          IST_OVF   = 1;
  localparam int          IST_FIFO  = 2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        valid;
    logic        ide;
    logic [10:0] sid;
    logic [17:0] eid;
  } caf_rx_id_t;

  typedef struct packed {
    logic       valid;
    logic       hit;
    logic       to_fifo;
    logic       buf_wr;
    logic       ovf;
    logic [3:0] filt;
    logic [3:0] dest;
  } caf_result_t;

endpackage : caf_pkg

/* hdl/caf_rx_filter.sv */
// CAN receive acceptance filter with APB register slave and interrupt.
`timescale 1ns/100ps
`default_nettype none
module caf_rx_filter #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Protocol engine side
  input  wire caf_pkg::caf_rx_id_t  rx_id_i,
  output caf_pkg::caf_result_t      result_o,
  // Interrupt
  output logic                      irq
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (ADDR_W < 8) begin : g_bad_addr
    $error("caf_rx_filter: ADDR_W must be at least 8");
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0] ptr_q [0:3];
  logic [15:0] msel_q;
  logic [15:0] fen_q;
  logic [caf_pkg::NUM_BUF-1:0] full_q;
  logic [caf_pkg::NUM_BUF-1:0] ovf_q;
  logic [2:0]  ist_q;
  logic [2:0]  imask_q;
  logic [8:0]  last_q;
  logic [10:0] fsid_q  [0:caf_pkg::NUM_FILT-1];
  logic [17:0] feid_q  [0:caf_pkg::NUM_FILT-1];
  logic        fexide_q [0:caf_pkg::NUM_FILT-1];
  logic [10:0] msid_q  [0:caf_pkg::NUM_MASK-1];
  logic [17:0] meid_q  [0:caf_pkg::NUM_MASK-1];
  logic        mmide_q [0:caf_pkg::NUM_MASK-1];
  logic [31:0] prdata_q;
  logic        err_q;
  caf_pkg::caf_result_t result_q;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic [7:0] a;
  logic       wr_acc;
  logic       rd_acc;
  logic       setup;
  logic [3:0] fidx;
  logic [1:0] midx;

  function automatic logic in_mask(input logic [7:0] ad,
                                   input logic [7:0] base);
    return (ad[7:4] == base[7:4]) && (ad[3:2] != 2'b11) &&
           (ad[1:0] == 2'b00);
  endfunction : in_mask

  function automatic logic in_filt(input logic [7:0] ad,
                                   input logic [7:0] base);
    return (ad[7:6] == base[7:6]) && (ad[1:0] == 2'b00);
  endfunction : in_filt

  assign a      = paddr[7:0];
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign setup  = psel & ~penable;
  assign fidx   = a[5:2];
  assign midx   = a[3:2];
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = err_q;

  // ****************************************************************
  // Filter evaluation
  // ****************************************************************
  logic [caf_pkg::NUM_FILT-1:0] match_vec;
  logic [3:0] fptr [0:caf_pkg::NUM_FILT-1];

  function automatic logic id_match(input caf_pkg::caf_rx_id_t id,
                                    input logic [10:0] fs,
                                    input logic [17:0] fe,
                                    input logic        fx,
                                    input logic [10:0] ms,
                                    input logic [17:0] me,
                                    input logic        mask_id_type_mode);
    logic sid_ok;
    logic eid_ok;
    logic type_ok;
    sid_ok  = ((id.sid ^ fs) & ms) == 11'h000;
    eid_ok  = ((id.eid ^ fe) & me) == 18'h00000;
    type_ok = !mask_id_type_mode || (id.ide == fx);
    return sid_ok && type_ok && (!id.ide || eid_ok);
  endfunction : id_match

  for (genvar g = 0; g < caf_pkg::NUM_FILT; g++) begin : g_filt
    logic [1:0]  code;
    logic [10:0] ms;
    logic [17:0] me;
    logic        mask_id_type_mode;
    // Filters 8 to 15 have no mask-select field and always use mask 0.
    if (g < 8) begin : g_sel
      assign code = msel_q[2*g+1:2*g];
    end else begin : g_nosel
      assign code = 2'h0;
    end
    assign ms   = (code == caf_pkg::MSEL_NONE) ? 11'h7FF : msid_q[code];
    assign me   = (code == caf_pkg::MSEL_NONE) ? 18'h3FFFF : meid_q[code];
    assign mask_id_type_mode = (code == caf_pkg::MSEL_NONE) ? 1'b0 : mmide_q[code];
    assign fptr[g] = ptr_q[g/4][(g%4)*4 +: 4];
    assign match_vec[g] = fen_q[g] &&
      id_match(rx_id_i, fsid_q[g], feid_q[g], fexide_q[g], ms, me, mask_id_type_mode);
  end

  logic [3:0] win;
  logic [3:0] win_ptr;
  logic       any_hit;
  logic [15:0] full16;
  logic [15:0] ovf16;

  always_comb begin
    win = 4'h0;
    for (int i = caf_pkg::NUM_FILT - 1; i >= 0; i--) begin
      if (match_vec[i]) begin
        win = 4'(i);
      end
    end
  end

  assign any_hit = rx_id_i.valid && (match_vec != 16'h0000);
  assign win_ptr = fptr[win];
  assign full16  = {1'b0, full_q};
  assign ovf16   = {1'b0, ovf_q};

  logic [caf_pkg::NUM_BUF-1:0] full_set;
  logic [caf_pkg::NUM_BUF-1:0] ovf_set;
  logic [2:0] ist_set;
  logic       to_buf;

  assign to_buf = any_hit && (win_ptr != caf_pkg::PTR_FIFO);

  always_comb begin
    for (int b = 0; b < caf_pkg::NUM_BUF; b++) begin
      full_set[b] = to_buf && (win_ptr == 4'(b));
      ovf_set[b]  = to_buf && (win_ptr == 4'(b)) && full_q[b];
    end
  end

  assign ist_set[caf_pkg::IST_BUF]  = to_buf && !full16[win_ptr];
  assign ist_set[caf_pkg::IST_OVF]  = to_buf && full16[win_ptr];
  assign ist_set[caf_pkg::IST_FIFO] = any_hit && !to_buf;

  // ****************************************************************
  // Result, one cycle after the identifier
  // ****************************************************************
  // A full buffer is not written again, so its old message survives.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= '0;
    end else begin
      result_q.valid   <= rx_id_i.valid;
      result_q.hit     <= any_hit;
      result_q.to_fifo <= any_hit && !to_buf;
      result_q.buf_wr  <= to_buf && !full16[win_ptr];
      result_q.ovf     <= to_buf && full16[win_ptr];
      result_q.filt    <= any_hit ? win : 4'h0;
      result_q.dest    <= any_hit ? win_ptr : 4'h0;
    end
  end

  assign result_o = result_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 9'h000;
    end else if (any_hit) begin
      last_q <= {1'b1, win, win_ptr};
    end
  end

  // ****************************************************************
  // Software-written configuration
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < 4; k++) begin
        ptr_q[k] <= caf_pkg::PTR_RST;
      end
    end else if (wr_acc && a[7:4] == caf_pkg::OFF_PTR_BASE[7:4] &&
                 a[1:0] == 2'b00) begin
      ptr_q[a[3:2]] <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msel_q  <= caf_pkg::MSEL_RST;
      fen_q   <= caf_pkg::FEN_RST;
      imask_q <= 3'h0;
    end else if (wr_acc) begin
      if (a == caf_pkg::OFF_MSEL) begin
        msel_q <= pwdata[15:0];
      end
      if (a == caf_pkg::OFF_FEN) begin
        fen_q <= pwdata[15:0];
      end
      if (a == caf_pkg::OFF_IMASK) begin
        imask_q <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int f = 0; f < caf_pkg::NUM_FILT; f++) begin
        fsid_q[f]   <= 11'h000;
        feid_q[f]   <= 18'h00000;
        fexide_q[f] <= 1'b0;
      end
    end else if (wr_acc && in_filt(a, caf_pkg::OFF_FSID_BASE)) begin
      fsid_q[fidx]        <= pwdata[15:5];
      fexide_q[fidx]      <= pwdata[3];
      feid_q[fidx][17:16] <= pwdata[1:0];
    end else if (wr_acc && in_filt(a, caf_pkg::OFF_FEID_BASE)) begin
      feid_q[fidx][15:0]  <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int m = 0; m < caf_pkg::NUM_MASK; m++) begin
        msid_q[m]  <= 11'h000;
        meid_q[m]  <= 18'h00000;
        mmide_q[m] <= 1'b0;
      end
    end else if (wr_acc && in_mask(a, caf_pkg::OFF_MSID_BASE)) begin
      msid_q[midx]        <= pwdata[15:5];
      mmide_q[midx]       <= pwdata[3];
      meid_q[midx][17:16] <= pwdata[1:0];
    end else if (wr_acc && in_mask(a, caf_pkg::OFF_MEID_BASE)) begin
      meid_q[midx][15:0]  <= pwdata[15:0];
    end
  end

  // ****************************************************************
  // Hardware-set flags
  // ****************************************************************
  // Software clears a flag by writing zero to it; a set in the same
  // cycle wins so no event is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_q <= '0;
      ovf_q  <= '0;
    end else begin
      if (wr_acc && a == caf_pkg::OFF_FULL) begin
        full_q <= (full_q & pwdata[caf_pkg::NUM_BUF-1:0]) | full_set;
      end else begin
        full_q <= full_q | full_set;
      end
      if (wr_acc && a == caf_pkg::OFF_OVF) begin
        ovf_q <= (ovf_q & pwdata[caf_pkg::NUM_BUF-1:0]) | ovf_set;
      end else begin
        ovf_q <= ovf_q | ovf_set;
      end
    end
  end

  // Read data is captured in the setup cycle, so only the bits that
  // software actually saw are cleared at the access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= 3'h0;
    end else if (rd_acc && a == caf_pkg::OFF_IST) begin
      ist_q <= (ist_q & ~prdata_q[2:0]) | ist_set;
    end else begin
      ist_q <= ist_q | ist_set;
    end
  end

  assign irq = |(ist_q & imask_q);

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [15:0] rd_word;
  logic        rd_ok;

  always_comb begin
    rd_word = 16'h0000;
    rd_ok   = 1'b1;
    if (in_filt(a, caf_pkg::OFF_FSID_BASE)) begin
      rd_word = {fsid_q[fidx], 1'b0, fexide_q[fidx], 1'b0,
                 feid_q[fidx][17:16]};
    end else if (in_filt(a, caf_pkg::OFF_FEID_BASE)) begin
      rd_word = feid_q[fidx][15:0];
    end else if (in_mask(a, caf_pkg::OFF_MSID_BASE)) begin
      rd_word = {msid_q[midx], 1'b0, mmide_q[midx], 1'b0,
                 meid_q[midx][17:16]};
    end else if (in_mask(a, caf_pkg::OFF_MEID_BASE)) begin
      rd_word = meid_q[midx][15:0];
    end else if (a[7:4] == caf_pkg::OFF_PTR_BASE[7:4] &&
                 a[1:0] == 2'b00) begin
      rd_word = ptr_q[a[3:2]];
    end else begin
      case (a)
        caf_pkg::OFF_MSEL:  rd_word = msel_q;
        caf_pkg::OFF_FEN:   rd_word = fen_q;
        caf_pkg::OFF_FULL:  rd_word = full16;
        caf_pkg::OFF_OVF:   rd_word = ovf16;
        caf_pkg::OFF_IST:   rd_word = {13'h0000, ist_q};
        caf_pkg::OFF_IMASK: rd_word = {13'h0000, imask_q};
        caf_pkg::OFF_LAST:  rd_word = {7'h00, last_q};
        default:            rd_ok   = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      err_q    <= 1'b0;
    end else if (setup) begin
      prdata_q <= (pwrite || !rd_ok) ? 32'h00000000 : {16'h0000, rd_word};
      err_q    <= !rd_ok;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_fifo_route: assert property (
    result_o.hit && result_o.dest == caf_pkg::PTR_FIFO
      |-> result_o.to_fifo && !result_o.buf_wr && !result_o.ovf)
    else $error("FIFO pointer hit not routed to FIFO");

  chk_buf_full_set: assert property (
    result_o.buf_wr |-> full16[result_o.dest] && !$past(full16[win_ptr]))
    else $error("buffer write did not set full flag");

  chk_ovf_flag_set: assert property (
    result_o.ovf |-> ovf16[result_o.dest] && result_o.dest != 4'hF)
    else $error("overflow did not set overflow flag");

  chk_ptr_dest_map: assert property (
    rx_id_i.valid && any_hit |=> result_o.hit &&
      result_o.dest == $past(win_ptr) && result_o.filt == $past(win))
    else $error("hit destination not taken from pointer");

  chk_lowest_wins: assert property (
    result_o.hit |-> ($past(match_vec) &
      ((16'h0001 << result_o.filt) - 16'h0001)) == 16'h0000)
    else $error("a lower-numbered matching filter was skipped");

  chk_miss_discard: assert property (
    rx_id_i.valid && match_vec == 16'h0000
      |=> result_o.valid && !result_o.hit && !result_o.buf_wr &&
          !result_o.to_fifo && (full_q & ~$past(full_q)) == '0)
    else $error("unmatched message was not discarded");

  chk_one_cycle: assert property (
    rx_id_i.valid |=> result_o.valid ##1 !result_o.valid || $past(rx_id_i.valid))
    else $error("result not presented one cycle after identifier");

  chk_disabled_nohit: assert property (
    rx_id_i.valid && fen_q == 16'h0000 |=> !result_o.hit)
    else $error("hit with every filter disabled");

  chk_sid_exact: assert property (
    rx_id_i.valid && fen_q == 16'h0001 && !rx_id_i.ide &&
      msel_q[1:0] == caf_pkg::MSEL_NONE && rx_id_i.sid != fsid_q[0]
      |=> !result_o.hit)
    else $error("standard identifier mismatch produced a hit");

  chk_type_mode: assert property (
    rx_id_i.valid && fen_q == 16'h0001 && msel_q[1:0] == 2'h0 &&
      mmide_q[0] && rx_id_i.ide != fexide_q[0] |=> !result_o.hit)
    else $error("frame type ignored in type mode");

  chk_rsvd_zero: assert property (
    rd_acc && (in_filt(a, caf_pkg::OFF_FSID_BASE) ||
      in_mask(a, caf_pkg::OFF_MSID_BASE))
      |-> prdata[4] == 1'b0 && prdata[2] == 1'b0 && prdata[31:16] == 16'h0)
    else $error("unused identifier bits read nonzero");

  cov_fifo_hit: cover property (result_o.to_fifo);
  cov_buf_hit:  cover property (result_o.buf_wr);
  cov_overflow: cover property (result_o.ovf ##1 irq);
  cov_miss:     cover property (result_o.valid && !result_o.hit);

endmodule : caf_rx_filter
`default_nettype wire

/* dv/caf_engine_model.sv */
// Behavioural CAN protocol engine that delivers received identifiers.
`timescale 1ns/100ps
`default_nettype none
module caf_engine_model (
  // Clock
  input  wire logic                 pclk,
  // Identifier stream towards the filter
  output var caf_pkg::caf_rx_id_t   rx_id
);
  int seed = 32'h7FCD;

  initial rx_id = '0;

  // One identifier per call, valid for exactly one cycle.
  // Between frames the lines carry junk, so stale bits cannot pass for data.
  task automatic send(input logic ide, input logic [10:0] sid,
                      input logic [17:0] eid);
    @(posedge pclk);
    rx_id <= {1'b1, ide, sid, eid};
    @(posedge pclk);
    rx_id <= {1'b0, 30'($random(seed))};
  endtask : send
endmodule : caf_engine_model
`default_nettype wire

/* dv/test_can_rx_acceptance_filter.sv */
// Self-checking testbench for the CAN receive acceptance filter.
`timescale 1ns/100ps
`default_nettype none
module test_can_rx_acceptance_filter;
  logic                 pclk = 1'b0;
  logic                 presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, v, rd;
  caf_pkg::caf_rx_id_t  rx_id;
  caf_pkg::caf_result_t result_o, e;
  int                   failures = 0, compares = 0, seed = 32'h7FCD, k;
  logic [15:0]          fsid[16], feid[16], ptr[4], msid[3], meid[3];
  logic [15:0]          msel, fen;
  logic [14:0]          full, ovf;
  logic [2:0]           ist, imask;
  logic                 err;
  logic [8:0]           last;

  always #50 pclk = ~pclk;

  caf_rx_filter #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rx_id_i(rx_id), .result_o(result_o), .irq(irq));
  caf_engine_model eng (.pclk(pclk), .rx_id(rx_id));

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic conclude();
    $display("Compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // The master waits for pready; only the watchdog ends a hung wait.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [15:0] ex);
    apb(1'b0, a, 32'h0);
    chk(nm, {16'h0, ex}, rd);
    chk("pslverr", 32'h0, {31'h0, err});
  endtask : rdc

  // One identifier through the model and the design, then compared.
  task automatic idc(input logic ide, input logic [10:0] sid,
                     input logic [17:0] eid);
    e = predict(ide, sid, eid);
    eng.send(ide, sid, eid);
    #1;
    chk("result", {19'h0, e}, {19'h0, result_o});
    chk("irq", {31'h0, |(ist & imask)}, {31'h0, irq});
  endtask : idc

  // ****************************************************************
  // Reference model of acceptance
  // ****************************************************************
  function automatic caf_pkg::caf_result_t predict(input logic ide,
      input logic [10:0] sid, input logic [17:0] eid);
    caf_pkg::caf_result_t r;
    logic [15:0] ms, me;
    int m;
    r = '0;
    r.valid = 1'b1;
    for (int n = 15; n >= 0; n--) begin
      m = (n < 8) ? int'(msel[2*n +: 2]) : 0;
      ms = (m == 3) ? 16'hFFE3 : msid[m];
      me = (m == 3) ? 16'hFFFF : meid[m];
      if (fen[n] && (((sid ^ fsid[n][15:5]) & ms[15:5]) == 11'h000) &&
          (!ide || ((({fsid[n][1:0], feid[n]} ^ eid) & {ms[1:0], me})
                    == 18'h00000)) && (!ms[3] || ide == fsid[n][3])) begin
        r.hit = 1'b1;
        r.filt = 4'(n);
        r.dest = ptr[n/4][4*(n%4) +: 4];
      end
    end
    if (r.hit) last = {1'b1, r.filt, r.dest};
    if (r.hit && r.dest == 4'hF) begin
      r.to_fifo = 1'b1;
      ist[2] = 1'b1;
    end else if (r.hit && full[r.dest]) begin
      r.ovf = 1'b1;
      ovf[r.dest] = 1'b1;
      ist[1] = 1'b1;
    end else if (r.hit) begin
      r.buf_wr = 1'b1;
      full[r.dest] = 1'b1;
      ist[0] = 1'b1;
    end
    return r;
  endfunction : predict

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    foreach (fsid[n]) {fsid[n], feid[n]} = 32'h0;
    foreach (msid[m]) {msid[m], meid[m]} = 32'h0;
    ptr = '{default: 16'h0000};
    {msel, full, ovf, ist, imask, last} = '0;
    fen = 16'h003F;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) rdc("ptr", 8'(4*i), 16'h0000);
    rdc("msel", caf_pkg::OFF_MSEL, 16'h0000);
    rdc("fen", caf_pkg::OFF_FEN, 16'h003F);
    rdc("full", caf_pkg::OFF_FULL, 16'h0000);
    rdc("ovf", caf_pkg::OFF_OVF, 16'h0000);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    for (int r = 0; r < 6; r++) begin
      for (int n = 0; n < 16; n++) begin
        v = $random(seed);
        apb(1'b1, 8'(8'h40 + 4*n), v);
        fsid[n] = v[15:0] & 16'hFFEB;
        v = $random(seed);
        apb(1'b1, 8'(8'h80 + 4*n), v);
        feid[n] = v[15:0];
      end
      for (int i = 0; i < 3; i++) begin
        v = $random(seed);
        apb(1'b1, 8'(8'hC0 + 4*i), v);
        msid[i] = v[15:0] & 16'hFFEB;
        v = $random(seed);
        apb(1'b1, 8'(8'hD0 + 4*i), v);
        meid[i] = v[15:0];
        rdc("mask std", 8'(8'hC0 + 4*i), msid[i]);
      end
      for (int i = 0; i < 4; i++) begin
        ptr[i] = 16'($random(seed));
        apb(1'b1, 8'(4*i), {16'h0, ptr[i]});
      end
      msel = 16'($random(seed));
      apb(1'b1, caf_pkg::OFF_MSEL, {16'h0, msel});
      fen = 16'($random(seed)) | 16'($random(seed));
      apb(1'b1, caf_pkg::OFF_FEN, {16'h0, fen});
      imask = 3'($random(seed));
      apb(1'b1, caf_pkg::OFF_IMASK, {29'h0, imask});
      for (int n = 0; n < 16; n++)
        rdc("filter std", 8'(8'h40 + 4*n), fsid[n]);
      for (int j = 0; j < 40; j++) begin
        k = int'(4'($random(seed)));
        v = $random(seed);
        rd = $random(seed);
        idc(v[20], fsid[k][15:5] ^ (v[3:0] == 4'h0 ? v[14:4] : 11'h0),
            {fsid[k][1:0], feid[k]} ^ (v[18:16] == 3'h0 ? rd[17:0] : 18'h0));
      end
      rdc("int status", caf_pkg::OFF_IST, {13'h0, ist});
      ist = 3'h0;
      rdc("full", caf_pkg::OFF_FULL, {1'b0, full});
      rdc("ovf", caf_pkg::OFF_OVF, {1'b0, ovf});
      rdc("last hit", caf_pkg::OFF_LAST, {7'h0, last});
      v = $random(seed);
      apb(1'b1, caf_pkg::OFF_FULL, v);
      full = full & v[14:0];
      apb(1'b1, caf_pkg::OFF_OVF, v);
      ovf = ovf & v[14:0];
    end
    // Corners that random setup never reaches: every filter off, filter 0
    // alone without a mask, then filter 0 under identifier type mode.
    fen = 16'h0000;
    apb(1'b1, caf_pkg::OFF_FEN, 32'h0);
    idc(1'b0, fsid[0][15:5], 18'h0);
    fen = 16'h0001;
    msel = 16'h0003;
    apb(1'b1, caf_pkg::OFF_FEN, 32'h1);
    apb(1'b1, caf_pkg::OFF_MSEL, 32'h3);
    idc(1'b0, ~fsid[0][15:5], 18'h0);
    idc(1'b0, fsid[0][15:5], ~{fsid[0][1:0], feid[0]});
    idc(1'b1, fsid[0][15:5], {fsid[0][1:0], feid[0]});
    idc(1'b1, fsid[0][15:5], ~{fsid[0][1:0], feid[0]});
    msel = 16'h0000;
    msid[0] = 16'h0008;
    meid[0] = 16'h0000;
    apb(1'b1, caf_pkg::OFF_MSEL, 32'h0);
    apb(1'b1, caf_pkg::OFF_MSID_BASE, 32'h8);
    apb(1'b1, caf_pkg::OFF_MEID_BASE, 32'h0);
    idc(!fsid[0][3], ~fsid[0][15:5], 18'h0);
    idc(fsid[0][3], ~fsid[0][15:5], 18'h3FFFF);
    rdc("int status", caf_pkg::OFF_IST, {13'h0, ist});
    rdc("last hit", caf_pkg::OFF_LAST, {7'h0, last});
    conclude();
  end

  initial begin
    #1000000;
    failures++;
    conclude();
  end
endmodule : test_can_rx_acceptance_filter
`default_nettype wire
